// File: iwdt_pkg.sv
// shared constants, types and default lookup tables of the independent watchdog
package iwdt_pkg;

	localparam int COUNT_W = 14;
	localparam int ADDR_W  = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REFRESH_OFS    = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h04;
	localparam logic [ADDR_W-1:0] CONTROL_OFS    = 8'h08;
	localparam logic [ADDR_W-1:0] RESET_CTRL_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] STOP_CTRL_OFS  = 8'h10;
	localparam logic [ADDR_W-1:0] MASK_OFS       = 8'h14;

	// refresh key bytes
	localparam logic [7:0] REFRESH_FIRST  = 8'h00;
	localparam logic [7:0] REFRESH_SECOND = 8'hFF;

	// field positions
	localparam int CTRL_TIMEOUT_LSB = 0;
	localparam int CTRL_DIV_LSB     = 4;
	localparam int CTRL_WEND_LSB    = 8;
	localparam int CTRL_WSTART_LSB  = 12;
	localparam int RSTIRQ_BIT       = 7;
	localparam int LPSTOP_BIT       = 7;
	localparam int STS_UNDERFLOW    = 14;
	localparam int STS_REFERR       = 15;
	localparam int EV_UNDERFLOW     = 0;
	localparam int EV_REFERR        = 1;

	// reset values
	localparam logic [15:0]        CONTROL_RESET    = 16'h0000;
	localparam logic [7:0]         RESET_CTRL_RESET = 8'h00;
	localparam logic [7:0]         STOP_CTRL_RESET  = 8'h00;
	localparam logic [1:0]         MASK_RESET       = 2'h0;
	localparam logic [COUNT_W-1:0] COUNT_RESET      = 14'h0000;

	// reload value per timeout select code
	localparam logic [COUNT_W-1:0] RELOAD_TABLE [4] = '{14'h007F, 14'h01FF, 14'h03FF, 14'h07FF};

	// integrator tables: divide ratio per code, window edges in percent of the period
	localparam logic [8:0] DIV_RATIO_DEFAULT [16] = '{9'h001, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100,
		9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001};
	localparam int WIN_START_PCT_DEFAULT [4] = '{100, 75, 50, 25};
	localparam int WIN_END_PCT_DEFAULT   [4] = '{0, 25, 50, 75};
	localparam int PCT_FULL              = 100;

	typedef struct packed {
		logic [3:0] divider_select;
		logic [1:0] timeout_select;
		logic [1:0] window_start_select;
		logic [1:0] window_end_select;
		logic       reset_or_interrupt_select;
		logic       low_power_count_halt;
	} wdt_cfg_t;

	typedef struct packed {
		logic     auto_start;
		wdt_cfg_t cfg;
	} option_setting_word_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_COUNT = 2'b01,
		ST_HALT  = 2'b11
	} wdt_state_t;

endpackage : iwdt_pkg

// File: iwdt_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module iwdt_sync3 (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// level in and out
	input  wire logic d_i,
	output logic      q_o
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a change only once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= 1'b0;
		end else if (s2 == s3) begin
			q_o <= s3;
		end
	end
endmodule : iwdt_sync3
`default_nettype wire

// File: iwdt_prescaler.sv
// counts watchdog clock edges and emits one tick per selected ratio
`timescale 1ns/1ps
`default_nettype none
module iwdt_prescaler (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       clear_i,
	input  wire logic       edge_i,
	input  wire logic [8:0] ratio_i,
	// tick out
	output logic            tick_o
);
	logic [7:0] cnt;
	logic [8:0] last;

	assign last   = ratio_i - 9'h001;
	assign tick_o = edge_i && ({1'b0, cnt} == last);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
		end else if (clear_i || tick_o) begin
			cnt <= 8'h00;
		end else if (edge_i) begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : iwdt_prescaler
`default_nettype wire

// File: iwdt_top.sv
// independent watchdog timer with apb registers
`timescale 1ns/1ps
`default_nettype none
module iwdt_top
	import iwdt_pkg::*;
#(
	parameter logic [8:0] DIV_RATIO     [16] = iwdt_pkg::DIV_RATIO_DEFAULT,
	parameter int         WIN_START_PCT [4]  = iwdt_pkg::WIN_START_PCT_DEFAULT,
	parameter int         WIN_END_PCT   [4]  = iwdt_pkg::WIN_END_PCT_DEFAULT
) (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           resetn_i,
	// apb slave
	input  wire iwdt_pkg::apb_req_t             apb_req_i,
	output iwdt_pkg::apb_rsp_t                  apb_rsp_o,
	// watchdog clock, option word and power state
	input  wire logic                           watchdog_dedicated_clock_i,
	input  wire iwdt_pkg::option_setting_word_t option_setting_word_i,
	input  wire logic                           low_power_i,
	// requests and status
	output logic                                reset_request_o,
	output logic                                underflow_nmi_o,
	output logic                                low_power_stop_o,
	output logic                                irq_o
);
	import iwdt_pkg::*;

	logic                 rst_meta;
	logic                 rst_n;
	logic                 wclk_s;
	logic                 wclk_d;
	logic                 wclk_rise;
	logic                 low_power_s;
	logic                 tick;
	wdt_state_t           state;
	wdt_state_t           next_state;
	wdt_cfg_t             active_cfg;
	wdt_cfg_t             next_cfg;
	wdt_cfg_t             reg_cfg;
	option_setting_word_t option_word;
	logic                 option_taken;
	logic [15:0]          control;
	logic [7:0]           reset_control_register;
	logic [7:0]           stop_control;
	logic [1:0]           event_flags;
	logic [1:0]           event_mask;
	logic [COUNT_W-1:0]   count;
	logic [COUNT_W-1:0]   start_pos;
	logic [COUNT_W-1:0]   end_pos;
	logic                 armed;
	logic                 setup_ph;
	logic                 wr_access;
	logic                 mapped;
	logic                 refresh_done;
	logic                 in_window;
	logic                 counting;
	logic                 start_ev;
	logic                 underflow_ev;
	logic                 referr_ev;
	logic                 timeout_ev;
	logic                 reload_ok;
	logic [1:0]           clear_bits;
	logic [31:0]          rdata;
	logic                 slverr;
	logic [31:0]          prdata_q;

	// window edge as a count value, from a percentage of the period
	function automatic logic [COUNT_W-1:0] win_pos(input logic [COUNT_W-1:0] load, input int pct);
		int tmp;
		tmp = ((int'(load) + 1) * pct) / PCT_FULL;
		return tmp[COUNT_W-1:0];
	endfunction : win_pos

	// reset release through two flops
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// the watchdog clock is sampled, not used as a clock, so it must stay well below clk_i / 6
	iwdt_sync3 u_sync_wclk (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     (watchdog_dedicated_clock_i),
		.q_o     (wclk_s)
	);

	iwdt_sync3 u_sync_lp (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     (low_power_i),
		.q_o     (low_power_s)
	);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wclk_d <= 1'b0;
		end else begin
			wclk_d <= wclk_s;
		end
	end

	assign wclk_rise = wclk_s && !wclk_d;

	// option word caught once, at the first edge after reset release
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			option_word  <= '0;
			option_taken <= 1'b0;
		end else if (!option_taken) begin
			option_word  <= option_setting_word_i;
			option_taken <= 1'b1;
		end
	end

	// apb decode; zero wait states, read data captured in the setup cycle
	assign setup_ph  = apb_req_i.psel && !apb_req_i.penable;
	assign wr_access = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && !slverr;
	assign mapped    = (apb_req_i.paddr == REFRESH_OFS) || (apb_req_i.paddr == STATUS_OFS)
		|| (apb_req_i.paddr == CONTROL_OFS) || (apb_req_i.paddr == RESET_CTRL_OFS)
		|| (apb_req_i.paddr == STOP_CTRL_OFS) || (apb_req_i.paddr == MASK_OFS);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			slverr <= 1'b0;
		end else if (setup_ph) begin
			slverr <= !mapped;
		end
	end

	// software-written settings
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			control                <= CONTROL_RESET;
			reset_control_register <= RESET_CTRL_RESET;
			stop_control           <= STOP_CTRL_RESET;
			event_mask             <= MASK_RESET;
		end else if (wr_access) begin
			case (apb_req_i.paddr)
				CONTROL_OFS: begin
					control <= apb_req_i.pwdata[15:0];
				end
				RESET_CTRL_OFS: begin
					reset_control_register <= apb_req_i.pwdata[7:0];
				end
				STOP_CTRL_OFS: begin
					stop_control <= apb_req_i.pwdata[7:0];
				end
				MASK_OFS: begin
					// mask bits sit at the same positions as the status flags
					event_mask <= {apb_req_i.pwdata[STS_REFERR], apb_req_i.pwdata[STS_UNDERFLOW]};
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		reg_cfg.divider_select            = control[CTRL_DIV_LSB +: 4];
		reg_cfg.timeout_select            = control[CTRL_TIMEOUT_LSB +: 2];
		reg_cfg.window_start_select       = control[CTRL_WSTART_LSB +: 2];
		reg_cfg.window_end_select         = control[CTRL_WEND_LSB +: 2];
		reg_cfg.reset_or_interrupt_select = reset_control_register[RSTIRQ_BIT];
		reg_cfg.low_power_count_halt      = stop_control[LPSTOP_BIT];
	end

	// refresh key: 00h arms, FFh completes; any other write to the register disarms
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (wr_access && (apb_req_i.paddr == REFRESH_OFS)) begin
			armed <= (apb_req_i.pwdata[7:0] == REFRESH_FIRST);
		end
	end

	assign refresh_done = wr_access && (apb_req_i.paddr == REFRESH_OFS) && armed
		&& (apb_req_i.pwdata[7:0] == REFRESH_SECOND);

	// window bounds of the running period
	assign start_pos = win_pos(RELOAD_TABLE[active_cfg.timeout_select],
		WIN_START_PCT[active_cfg.window_start_select]);
	assign end_pos   = win_pos(RELOAD_TABLE[active_cfg.timeout_select],
		WIN_END_PCT[active_cfg.window_end_select]);
	assign in_window = (count <= start_pos) && (count >= end_pos);

	// count halts in low power only when the stop bit is set
	assign counting = (state == ST_COUNT) && !(active_cfg.low_power_count_halt && low_power_s);

	iwdt_prescaler u_prescaler (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.clear_i (start_ev || reload_ok || timeout_ev),
		.edge_i  (wclk_rise && counting),
		.ratio_i (DIV_RATIO[active_cfg.divider_select]),
		.tick_o  (tick)
	);

	// events
	assign start_ev     = (state == ST_IDLE) && option_taken
		&& (option_word.auto_start || refresh_done);
	assign underflow_ev = counting && tick && (count == COUNT_RESET);
	assign referr_ev    = (state == ST_COUNT) && refresh_done && !in_window;
	assign reload_ok    = (state == ST_COUNT) && refresh_done && in_window;
	assign timeout_ev   = underflow_ev || referr_ev;

	// settings chosen at start: option word in auto-start, registers otherwise
	assign next_cfg = option_word.auto_start ? option_word.cfg : reg_cfg;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_ev) begin
					next_state = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (timeout_ev && !option_word.auto_start) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				next_state = ST_HALT;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// later register writes do not disturb a running period
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			active_cfg <= '0;
		end else if (start_ev) begin
			active_cfg <= next_cfg;
		end
	end

	// down-counter
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			count <= COUNT_RESET;
		end else if (start_ev) begin
			count <= RELOAD_TABLE[next_cfg.timeout_select];
		end else if (reload_ok || (timeout_ev && option_word.auto_start)) begin
			count <= RELOAD_TABLE[active_cfg.timeout_select];
		end else if (counting && tick && !underflow_ev) begin
			count <= count - 14'h0001;
		end
	end

	// one-cycle request pulses
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reset_request_o <= 1'b0;
			underflow_nmi_o <= 1'b0;
		end else begin
			reset_request_o <= timeout_ev && active_cfg.reset_or_interrupt_select;
			underflow_nmi_o <= timeout_ev && !active_cfg.reset_or_interrupt_select;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_power_stop_o <= 1'b0;
		end else begin
			low_power_stop_o <= (state != ST_IDLE) && active_cfg.low_power_count_halt;
		end
	end

	// sticky event flags, write one to clear; a new event beats a clear
	assign clear_bits = (wr_access && (apb_req_i.paddr == STATUS_OFS))
		? {apb_req_i.pwdata[STS_REFERR], apb_req_i.pwdata[STS_UNDERFLOW]} : 2'h0;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			event_flags <= 2'h0;
		end else begin
			event_flags[EV_UNDERFLOW] <= underflow_ev || (event_flags[EV_UNDERFLOW] && !clear_bits[EV_UNDERFLOW]);
			event_flags[EV_REFERR]    <= referr_ev || (event_flags[EV_REFERR] && !clear_bits[EV_REFERR]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_flags & event_mask);
		end
	end

	// read mux, captured in the setup cycle
	always_comb begin
		rdata = 32'h0000_0000;
		case (apb_req_i.paddr)
			STATUS_OFS: begin
				rdata[COUNT_W-1:0]   = count;
				rdata[STS_UNDERFLOW] = event_flags[EV_UNDERFLOW];
				rdata[STS_REFERR]    = event_flags[EV_REFERR];
			end
			CONTROL_OFS: begin
				rdata[15:0] = control;
			end
			RESET_CTRL_OFS: begin
				rdata[7:0] = reset_control_register;
			end
			STOP_CTRL_OFS: begin
				rdata[7:0] = stop_control;
			end
			MASK_OFS: begin
				rdata[STS_UNDERFLOW] = event_mask[EV_UNDERFLOW];
				rdata[STS_REFERR]    = event_mask[EV_REFERR];
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_ph && !apb_req_i.pwrite) begin
			prdata_q <= rdata;
		end
	end

	// whole response driven by one assignment, so no member has two kinds of driver
	assign apb_rsp_o = '{prdata: prdata_q, pready: 1'b1, pslverr: apb_req_i.psel && apb_req_i.penable && slverr};

endmodule : iwdt_top
`default_nettype wire

// File: iwdt_top_asserts.sv
// port-level assertions for the independent watchdog top
`timescale 1ns/1ps
`default_nettype none
module iwdt_top_asserts
	import iwdt_pkg::*;
(
	// clock and reset
	input wire logic                           clk_i,
	input wire logic                           resetn_i,
	// register bus
	input wire iwdt_pkg::apb_req_t             apb_req_i,
	input wire iwdt_pkg::apb_rsp_t             apb_rsp_o,
	// watchdog side
	input wire logic                           watchdog_dedicated_clock_i,
	input wire iwdt_pkg::option_setting_word_t option_setting_word_i,
	input wire logic                           low_power_i,
	input wire logic                           reset_request_o,
	input wire logic                           underflow_nmi_o,
	input wire logic                           low_power_stop_o,
	input wire logic                           irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic acc;
	logic rd;
	logic mapped;
	assign acc = apb_req_i.psel && apb_req_i.penable;
	assign rd = acc && !apb_req_i.pwrite;
	assign mapped = (apb_req_i.paddr[1:0] == 2'h0) && (apb_req_i.paddr <= MASK_OFS);

	a_pready_fixed: assert property (apb_req_i.psel |-> apb_rsp_o.pready)
		else $error("pready low");
	a_unmapped_error: assert property (acc && !mapped |-> apb_rsp_o.pslverr)
		else $error("unmapped access not refused");
	a_unmapped_read_zero: assert property (rd && !mapped |-> apb_rsp_o.prdata == 32'h0)
		else $error("unmapped read not zero");
	a_mapped_no_error: assert property (acc && mapped |-> !apb_rsp_o.pslverr)
		else $error("error on mapped access");
	a_refresh_reads_zero: assert property (rd && apb_req_i.paddr == REFRESH_OFS |-> apb_rsp_o.prdata == 32'h0)
		else $error("refresh register read nonzero");
	a_count_in_range: assert property (rd && apb_req_i.paddr == STATUS_OFS |-> apb_rsp_o.prdata[13:0] <= 14'h07FF)
		else $error("counter above largest reload");
	a_reset_one_pulse: assert property (reset_request_o |=> !reset_request_o)
		else $error("reset request longer than one cycle");
	a_nmi_one_pulse: assert property ($rose(underflow_nmi_o) |=> $fell(underflow_nmi_o))
		else $error("nmi request longer than one cycle");
	a_one_request_kind: assert property (!(reset_request_o && underflow_nmi_o))
		else $error("reset and nmi together");
	a_quiet_after_reset: assert property ($rose(resetn_i) |->
		(!reset_request_o && !underflow_nmi_o && !irq_o && !low_power_stop_o) [*2])
		else $error("outputs active after reset");

	c_reset_req: cover property (reset_request_o);
	c_nmi_req: cover property (underflow_nmi_o);
	c_irq_rise: cover property ($rose(irq_o));
	c_low_power_halt: cover property (low_power_stop_o && low_power_i);
endmodule : iwdt_top_asserts

bind iwdt_top iwdt_top_asserts chk_u (
	.clk_i(clk_i), .resetn_i(resetn_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
	.watchdog_dedicated_clock_i(watchdog_dedicated_clock_i), .option_setting_word_i(option_setting_word_i),
	.low_power_i(low_power_i), .reset_request_o(reset_request_o), .underflow_nmi_o(underflow_nmi_o),
	.low_power_stop_o(low_power_stop_o), .irq_o(irq_o)
);
`default_nettype wire

// File: independent_watchdog_timer_tb.sv
// self-checking testbench for the independent watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error %s expected %0h seen %0h", nm, exp, got); end end
module independent_watchdog_timer_tb;
	import iwdt_pkg::*;
	logic                 clk_i = 1'b0;
	logic                 resetn_i = 1'b0;
	apb_req_t             req = '0;
	apb_rsp_t             rsp;
	logic                 wdc = 1'b0;
	logic [1:0]           wdc_div = 2'h0;
	option_setting_word_t opt = '0;
	logic                 low_power = 1'b0;
	logic                 rst_req;
	logic                 nmi;
	logic                 lp_stop;
	logic                 irq;
	logic [31:0]          rdat;
	logic [13:0]          reload [4] = '{14'h007F, 14'h01FF, 14'h03FF, 14'h07FF};
	int                   bad_count = 0, tests_run = 0, cyc = 0, rst_cnt = 0, nmi_cnt = 0, pulse_cyc = 0, t0 = 0;

	iwdt_top dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .apb_req_i(req), .apb_rsp_o(rsp),
		.watchdog_dedicated_clock_i(wdc), .option_setting_word_i(opt), .low_power_i(low_power),
		.reset_request_o(rst_req), .underflow_nmi_o(nmi), .low_power_stop_o(lp_stop), .irq_o(irq)
	);

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// watchdog clock at clk/8, well below the sync limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		wdc_div <= wdc_div + 2'h1;
		if (wdc_div == 2'h3)
			wdc <= ~wdc;
		if (rst_req === 1'b1)
			rst_cnt <= rst_cnt + 1;
		if (nmi === 1'b1)
			nmi_cnt <= nmi_cnt + 1;
		if (rst_req === 1'b1 || nmi === 1'b1)
			pulse_cyc <= cyc;
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20)
			bad_count++;
		rdat = rsp.prdata;
		t0 = cyc;
		`CHK("slave error", (a > MASK_OFS), rsp.pslverr)
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic refresh;
		apb(1'b1, REFRESH_OFS, {24'h0, REFRESH_FIRST});
		apb(1'b1, REFRESH_OFS, {24'h0, REFRESH_SECOND});
	endtask : refresh

	task automatic do_reset;
		resetn_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : do_reset

	// bounded wait for the next reset or nmi pulse
	task automatic wait_pulse(input int lim);
		int k, n;
		k = rst_cnt + nmi_cnt;
		n = 0;
		while (rst_cnt + nmi_cnt == k && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_pulse

	task automatic t_reset_values;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK("reset value", 32'h0, rdat)
		end
		apb(1'b0, 8'h18, 32'h0);
		`CHK("unmapped read", 32'h0, rdat)
		`CHK("idle outputs", 3'h0, {lp_stop, irq, rst_req})
		$display("test reset values done");
	endtask : t_reset_values

	task automatic t_underflow;
		int c, r0;
		do_reset;
		apb(1'b1, RESET_CTRL_OFS, 32'h80);
		r0 = rst_cnt;
		refresh;
		c = t0;
		wait_pulse(3000);
		`CHK("reset pulses", r0 + 1, rst_cnt)
		`CHK("timeout span", 1'b1, (pulse_cyc - c) inside {[1016:1040]})
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("underflow status", 16'h4000, rdat[15:0])
		refresh;
		repeat (40) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("halted count", 14'h0, rdat[13:0])
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, MASK_OFS, 32'h4000);
		repeat (2) @(posedge clk_i);
		`CHK("irq unmasked", 1'b1, irq)
		apb(1'b1, STATUS_OFS, 32'h4000);
		repeat (2) @(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq)
		$display("test underflow done");
	endtask : t_underflow

	task automatic t_window;
		int m0;
		do_reset;
		apb(1'b1, CONTROL_OFS, 32'h0200);
		refresh;
		repeat (100) @(posedge clk_i);
		refresh;
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("reload in window", 1'b1, rdat[13:0] >= 14'h007D)
		`CHK("no error flag", 2'h0, rdat[15:14])
		m0 = nmi_cnt;
		repeat (600) @(posedge clk_i);
		refresh;
		wait_pulse(20);
		`CHK("late refresh nmi", m0 + 1, nmi_cnt)
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("error flag", 1'b1, rdat[15])
		m0 = rdat[13:0];
		repeat (60) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("stopped after error", m0, int'(rdat[13:0]))
		do_reset;
		apb(1'b1, CONTROL_OFS, 32'h3000);
		apb(1'b1, RESET_CTRL_OFS, 32'h80);
		m0 = rst_cnt;
		refresh;
		refresh;
		wait_pulse(20);
		`CHK("early refresh reset", m0 + 1, rst_cnt)
		$display("test window done");
	endtask : t_window

	task automatic t_settings;
		int c, q;
		for (int k = 0; k < 4; k++) begin
			do_reset;
			apb(1'b1, CONTROL_OFS, 32'(k));
			refresh;
			apb(1'b0, STATUS_OFS, 32'h0);
			`CHK("reload", 1'b1, rdat[13:0] inside {[reload[k] - 14'h1 : reload[k]]})
		end
		for (int d = 1; d < 6; d++) begin
			do_reset;
			apb(1'b1, CONTROL_OFS, 32'(d << 4));
			refresh;
			c = t0;
			repeat (2100) @(posedge clk_i);
			apb(1'b0, STATUS_OFS, 32'h0);
			q = 127 - (t0 - c) / (8 * (16 << (d - 1)));
			`CHK("divided count", 1'b1, int'(rdat[13:0]) inside {[q - 1 : q + 1]})
		end
		$display("test settings done");
	endtask : t_settings

	task automatic t_low_power;
		int c;
		do_reset;
		apb(1'b1, STOP_CTRL_OFS, 32'h80);
		refresh;
		repeat (2) @(posedge clk_i);
		`CHK("stop signal", 1'b1, lp_stop)
		low_power <= 1'b1;
		repeat (10) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
		c = rdat[13:0];
		repeat (80) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("held in low power", c, int'(rdat[13:0]))
		low_power <= 1'b0;
		repeat (80) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("resumed", 1'b1, int'(rdat[13:0]) < c)
		$display("test low power done");
	endtask : t_low_power

	task automatic t_auto_start;
		int m0;
		opt.auto_start <= 1'b1;
		opt.cfg.low_power_count_halt <= 1'b1;
		do_reset;
		m0 = nmi_cnt;
		// counting starts four edges after release, the stop signal one edge later
		repeat (2) @(posedge clk_i);
		`CHK("auto stop signal", 1'b1, lp_stop)
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("auto counting", 1'b1, rdat[13:0] inside {[14'h007C : 14'h007F]})
		wait_pulse(1200);
		`CHK("auto nmi", m0 + 1, nmi_cnt)
		opt <= '0;
		$display("test auto start done");
	endtask : t_auto_start

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		conclude();
	end

	initial begin
		do_reset;
		t_reset_values;
		t_underflow;
		t_window;
		t_settings;
		t_low_power;
		t_auto_start;
		conclude();
	end
endmodule : independent_watchdog_timer_tb
`default_nettype wire
